// >>> csi_defs.svh
`ifndef CSI_DEFS_SVH
`define CSI_DEFS_SVH

// data-space addresses of the core registers
`define CSI_SPL_DADDR      8'h5d
`define CSI_SPH_DADDR      8'h5e
`define CSI_STATUS_FLAGS_REG_DADDR     8'h5f
// io-space form is data-space minus this offset
`define CSI_IO_TO_DATA     8'h20
// shared temporary byte, placed in a free slot
`define CSI_TEMP_DADDR     8'h4e

// stack pointer layout and reset value
`define CSI_SP_BITS        12
`define CSI_SP_RESET       12'h8ff
`define CSI_SPH_BITS       4

// global interrupt enable position in the status byte
`define CSI_GIE_BIT        7

// vector table layout
`define CSI_BOOT_START     16'h7000
`define CSI_VEC_STRIDE     16'h0002
`define CSI_NUM_VEC        8

// cycle figures of the sequences
`define CSI_ENTRY_CYC      2'd3
`define CSI_WAKE_CYC       2'd3
`define CSI_RETURN_CYC     2'd3
`define CSI_PUSH_CYC       2'd1

`endif

// >>> csi_pkg.sv
package csi_pkg;

   // one-hot sequencer states
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_WAKE  = 6'b000010,
      ST_ENTRY = 6'b000100,
      ST_CALL  = 6'b001000,
      ST_RET   = 6'b010000,
      ST_RETURN_FROM_IRQ_INSTR  = 6'b100000
   } csi_state_e;

   // register port access, one per cycle
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       io_space;
      logic [7:0] addr;
      logic [7:0] wdata;
   } csi_bus_req_s;

   // stack commands from the instruction sequencer
   typedef struct packed {
      logic push1;
      logic pop1;
      logic call;
      logic ret;
      logic return_from_irq_instr;
   } csi_stk_cmd_s;

   // request to the data memory holding the stack
   typedef struct packed {
      logic        we;
      logic        re;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } csi_mem_req_s;

endpackage : csi_pkg

// >>> csi_irq_src.sv
`timescale 1ns/10ps
// one interrupt source: latched flag or plain level
module csi_irq_src #(
   parameter bit IS_FLAG = 1'b1
) (
   // clock and reset
   input  wire logic ref_clk_in,
   input  wire logic reset_in,
   // source side
   input  wire logic cond_in,
   input  wire logic enable_in,
   // clears
   input  wire logic ack_in,
   input  wire logic sw_clr_in,
   // results
   output logic      flag_out,
   output logic      req_out
);

   logic flag_ff;

   // set beats clear so an event in the clearing cycle survives
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         flag_ff <= 1'b0;
      else if (IS_FLAG && cond_in)
         flag_ff <= 1'b1;
      else if (ack_in || sw_clr_in)
         flag_ff <= 1'b0;
   end

   // level sources only ask while the condition lasts
   assign flag_out = IS_FLAG ? flag_ff : 1'b0;
   assign req_out  = enable_in && (IS_FLAG ? flag_ff : cond_in);

endmodule : csi_irq_src

// >>> csi_prio_enc.sv
`timescale 1ns/10ps
// lowest index wins, matching the lowest vector address
module csi_prio_enc #(
   parameter int N  = 7,
   parameter int IW = 3
) (
   // requests
   input  wire logic [N-1:0]  req_in,
   // winner
   output logic               found_out,
   output logic [IW-1:0]      idx_out
);

   // scan downward so the last hit is the lowest index
   always_comb
   begin
      found_out = 1'b0;
      idx_out   = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req_in[i])
         begin
            found_out = 1'b1;
            idx_out   = IW'(i);
         end
      end
   end

endmodule : csi_prio_enc

// >>> csi_stack_irq_ctrl.sv
`timescale 1ns/10ps
`include "csi_defs.svh"
module csi_stack_irq_ctrl #(
   parameter int          NUM_VEC        = `CSI_NUM_VEC,
   parameter logic [NUM_VEC-2:0] FLAG_TYPE_MASK = '1,
   parameter logic [15:0] BOOT_START     = `CSI_BOOT_START,
   parameter logic [15:0] VEC_STRIDE     = `CSI_VEC_STRIDE,
   parameter logic [7:0]  TEMP_DADDR     = `CSI_TEMP_DADDR
) (
   // clock and reset
   input  wire logic                 ref_clk_in,
   input  wire logic                 reset_in,
   // register port
   input  wire csi_pkg::csi_bus_req_s io_req_in,
   output logic [7:0]                io_rdata_out,
   output logic                      io_hit_out,
   output logic                      status_flags_reg_wr_out,
   input  wire logic [6:0]           alu_flags_in,
   // instruction sequencer
   input  wire csi_pkg::csi_stk_cmd_s stk_cmd_in,
   input  wire logic [7:0]           push_data_in,
   input  wire logic [15:0]          call_addr_in,
   input  wire logic [15:0]          pc_in,
   input  wire logic                 instr_done_in,
   input  wire logic                 sleeping_in,
   input  wire logic                 sei_in,
   input  wire logic                 cli_in,
   output logic                      busy_out,
   output logic [15:0]               ret_pc_out,
   output logic                      ret_valid_out,
   output logic [15:0]               vec_pc_out,
   output logic                      vec_valid_out,
   output logic [15:0]               reset_pc_out,
   output logic [15:0]               stack_ptr_out,
   output logic                      global_irq_en_out,
   // stack memory
   output csi_pkg::csi_mem_req_s     mem_req_out,
   input  wire logic [7:0]           mem_rdata_in,
   // core control and fuses
   input  wire logic                 vector_table_select_in,
   input  wire logic                 reset_vector_relocate_fuse_in,
   input  wire logic                 boot_lock_bit_a_in,
   input  wire logic                 boot_lock_bit_b_in,
   // interrupt sources
   input  wire logic [NUM_VEC-2:0]   irq_cond_in,
   input  wire logic [NUM_VEC-2:0]   irq_en_in,
   input  wire logic [NUM_VEC-2:0]   irq_flag_clr_in,
   output logic [NUM_VEC-2:0]        irq_flag_out
);

   localparam int NS = NUM_VEC - 1;
   localparam int IW = $clog2(NUM_VEC);
   localparam int SW = `CSI_SP_BITS;

   csi_pkg::csi_state_e  state_ff;
   csi_pkg::csi_mem_req_s mem_req_ff;
   logic [1:0]           cnt_ff;
   logic [SW-1:0]        sp_ff;
   logic [7:0]           temp_ff;
   logic                 gie_ff;
   logic [15:0]          pc_save_ff;
   logic [15:0]          ret_pc_ff;
   logic                 ret_valid_ff;
   logic [15:0]          vec_pc_ff;
   logic                 vec_valid_ff;
   logic [IW-1:0]        win_ff;
   logic [7:0]           rdata_ff;
   logic [NS-1:0]        irq_req;
   logic [NS-1:0]        irq_ack;
   logic                 any_req;
   logic [IW-1:0]        win_idx;
   logic [7:0]           daddr;
   logic                 hit_spl;
   logic                 hit_sph;
   logic                 hit_status_flags_reg;
   logic                 hit_temp;
   logic                 boot_block;
   logic                 take;
   logic                 idle;
   logic                 sp_dec;
   logic                 sp_inc;

   // data-space address whichever form software used
   assign daddr    = io_req_in.io_space ? io_req_in.addr + `CSI_IO_TO_DATA
                                        : io_req_in.addr;
   assign hit_spl  = (daddr == `CSI_SPL_DADDR);
   assign hit_sph  = (daddr == `CSI_SPH_DADDR);
   assign hit_status_flags_reg = (daddr == `CSI_STATUS_FLAGS_REG_DADDR);
   assign hit_temp = (daddr == TEMP_DADDR);
   assign io_hit_out  = (io_req_in.rd || io_req_in.wr)
                        && (hit_spl || hit_sph || hit_status_flags_reg || hit_temp);
   assign status_flags_reg_wr_out = io_req_in.wr && hit_status_flags_reg;

   // per-source flag or level logic
   generate
      for (genvar g = 0; g < NS; g++)
      begin : g_src
         csi_irq_src #(
            .IS_FLAG   (FLAG_TYPE_MASK[g])
         ) u_src (
            .ref_clk_in(ref_clk_in),
            .reset_in  (reset_in),
            .cond_in   (irq_cond_in[g]),
            .enable_in (irq_en_in[g]),
            .ack_in    (irq_ack[g]),
            .sw_clr_in (irq_flag_clr_in[g]),
            .flag_out  (irq_flag_out[g]),
            .req_out   (irq_req[g])
         );
      end
   endgenerate

   // source g sits in vector slot g+1, reset owns slot 0
   csi_prio_enc #(
      .N        (NS),
      .IW       (IW)
   ) u_prio (
      .req_in   (irq_req),
      .found_out(any_req),
      .idx_out  (win_idx)
   );

   // lock bits guard whichever section is running
   assign boot_block = (pc_in < BOOT_START) ? boot_lock_bit_a_in
                                            : boot_lock_bit_b_in;

   // take only at an instruction boundary or from sleep; a
   // boundary that is itself the enable instruction never takes
   assign idle = (state_ff == csi_pkg::ST_IDLE);
   assign take = idle && gie_ff && any_req && !boot_block
                 && !cli_in
                 && !sei_in
                 && (instr_done_in || sleeping_in)
                 && !(stk_cmd_in.push1 || stk_cmd_in.pop1 || stk_cmd_in.call
                      || stk_cmd_in.ret || stk_cmd_in.return_from_irq_instr);

   // hardware clears the winning flag as it vectors
   always_comb
   begin
      irq_ack = '0;
      if (take)
         irq_ack[win_idx] = 1'b1;
   end

   // sequence state and cycle counter
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         state_ff <= csi_pkg::ST_IDLE;
         cnt_ff   <= 2'd0;
      end
      else
      begin
         cnt_ff <= cnt_ff + 2'd1;
         unique case (state_ff)
            csi_pkg::ST_IDLE:
            begin
               cnt_ff <= 2'd0;
               if (take)
                  state_ff <= sleeping_in ? csi_pkg::ST_WAKE
                                          : csi_pkg::ST_ENTRY;
               else if (stk_cmd_in.call)
                  state_ff <= csi_pkg::ST_CALL;
               else if (stk_cmd_in.ret)
                  state_ff <= csi_pkg::ST_RET;
               else if (stk_cmd_in.return_from_irq_instr)
                  state_ff <= csi_pkg::ST_RETURN_FROM_IRQ_INSTR;
            end
            csi_pkg::ST_WAKE:
               if (cnt_ff == `CSI_WAKE_CYC)
                  state_ff <= csi_pkg::ST_ENTRY;
            csi_pkg::ST_ENTRY:
               if (cnt_ff == `CSI_ENTRY_CYC)
                  state_ff <= csi_pkg::ST_IDLE;
            csi_pkg::ST_CALL:
               if (cnt_ff == `CSI_PUSH_CYC)
                  state_ff <= csi_pkg::ST_IDLE;
            csi_pkg::ST_RET,
            csi_pkg::ST_RETURN_FROM_IRQ_INSTR:
               if (cnt_ff == `CSI_RETURN_CYC)
                  state_ff <= csi_pkg::ST_IDLE;
         endcase
      end
   end

   // two pointer steps in the first two cycles of entry, call and both returns; wake has none
   assign sp_dec = (idle && stk_cmd_in.push1 && !take)
                   || ((state_ff == csi_pkg::ST_ENTRY || state_ff == csi_pkg::ST_CALL)
                       && !cnt_ff[1]);
   assign sp_inc = (idle && stk_cmd_in.pop1 && !take)
                   || ((state_ff == csi_pkg::ST_RET || state_ff == csi_pkg::ST_RETURN_FROM_IRQ_INSTR)
                       && !cnt_ff[1]);

   // stack pointer; software high write commits the temp byte
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         sp_ff <= `CSI_SP_RESET;
      else if (io_req_in.wr && hit_sph)
         sp_ff <= {io_req_in.wdata[`CSI_SPH_BITS-1:0], temp_ff};
      else if (sp_dec)
         sp_ff <= sp_ff - 1'b1;
      else if (sp_inc)
         sp_ff <= sp_ff + 1'b1;
   end
   assign stack_ptr_out = {{(16 - SW){1'b0}}, sp_ff};

   // shared temporary byte for pair accesses
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         temp_ff <= 8'h00;
      else if (io_req_in.wr && (hit_spl || hit_temp))
         temp_ff <= io_req_in.wdata;
      else if (io_req_in.rd && hit_spl)
         temp_ff <= {{(16 - SW){1'b0}}, sp_ff[SW-1:8]};
   end

   // read data, one cycle after the strobe
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         rdata_ff <= 8'h00;
      else if (io_req_in.rd)
      begin
         if (hit_spl)
            rdata_ff <= sp_ff[7:0];
         else if (hit_sph || hit_temp)
            rdata_ff <= temp_ff;
         else if (hit_status_flags_reg)
            rdata_ff <= {gie_ff, alu_flags_in};
         else
            rdata_ff <= 8'h00;
      end
   end
   assign io_rdata_out = rdata_ff;

   // global enable: hardware events outrank software writes
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         gie_ff <= 1'b0;
      else if (take)
         gie_ff <= 1'b0;
      else if (state_ff == csi_pkg::ST_RETURN_FROM_IRQ_INSTR && cnt_ff == `CSI_RETURN_CYC)
         gie_ff <= 1'b1;
      else if (cli_in)
         gie_ff <= 1'b0;
      else if (sei_in)
         gie_ff <= 1'b1;
      else if (io_req_in.wr && hit_status_flags_reg)
         gie_ff <= io_req_in.wdata[`CSI_GIE_BIT];
   end
   assign global_irq_en_out = gie_ff;

   // return address to push and the winning slot
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         pc_save_ff <= 16'h0000;
         win_ff     <= '0;
      end
      else if (take)
      begin
         pc_save_ff <= pc_in;
         win_ff     <= win_idx + 1'b1;
      end
      else if (idle && stk_cmd_in.call)
         pc_save_ff <= call_addr_in;
   end

   // memory request, registered; low byte goes first
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         mem_req_ff <= '0;
      else
      begin
         mem_req_ff.we    <= 1'b0;
         mem_req_ff.re    <= 1'b0;
         mem_req_ff.addr  <= {{(16 - SW){1'b0}}, sp_ff};
         mem_req_ff.wdata <= push_data_in;
         if (idle && stk_cmd_in.push1 && !take)
            mem_req_ff.we <= 1'b1;
         else if (sp_dec)
         begin
            mem_req_ff.we    <= 1'b1;
            mem_req_ff.wdata <= cnt_ff[0] ? pc_save_ff[15:8] : pc_save_ff[7:0];
         end
         else if (sp_inc)
         begin
            mem_req_ff.re   <= 1'b1;
            mem_req_ff.addr <= {{(16 - SW){1'b0}}, sp_ff + 1'b1};
         end
      end
   end
   assign mem_req_out = mem_req_ff;

   // popped bytes arrive one cycle after each registered request
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         ret_pc_ff    <= 16'h0000;
         ret_valid_ff <= 1'b0;
      end
      else
      begin
         ret_valid_ff <= 1'b0;
         if (state_ff == csi_pkg::ST_RET || state_ff == csi_pkg::ST_RETURN_FROM_IRQ_INSTR)
         begin
            if (cnt_ff == 2'd2)
               ret_pc_ff[15:8] <= mem_rdata_in;
            if (cnt_ff == `CSI_RETURN_CYC)
            begin
               ret_pc_ff[7:0] <= mem_rdata_in;
               ret_valid_ff   <= 1'b1;
            end
         end
      end
   end

   // vector address at the end of entry
   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         vec_pc_ff    <= 16'h0000;
         vec_valid_ff <= 1'b0;
      end
      else
      begin
         vec_valid_ff <= 1'b0;
         if (state_ff == csi_pkg::ST_ENTRY && cnt_ff == `CSI_ENTRY_CYC)
         begin
            vec_pc_ff    <= (vector_table_select_in ? BOOT_START : 16'h0000)
                            + 16'(16'(win_ff) * VEC_STRIDE);
            vec_valid_ff <= 1'b1;
         end
      end
   end

   assign ret_pc_out    = ret_pc_ff;
   assign ret_valid_out = ret_valid_ff;
   assign vec_pc_out    = vec_pc_ff;
   assign vec_valid_out = vec_valid_ff;
   assign busy_out      = !idle;
   assign reset_pc_out  = reset_vector_relocate_fuse_in ? BOOT_START
                                                        : 16'h0000;

   // checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   sequence s_entry;
      (state_ff == csi_pkg::ST_ENTRY)[*4] ##1 vec_valid_ff;
   endsequence
   sequence s_return_from_irq_instr;
      (state_ff == csi_pkg::ST_RETURN_FROM_IRQ_INSTR && !gie_ff)[*4] ##1 (gie_ff && ret_valid_ff);
   endsequence

   a_push_step: assert property (idle && stk_cmd_in.push1 && !take && !io_req_in.wr
      |=> sp_ff == $past(sp_ff) - 1'b1 && mem_req_ff.we) else $error("push step");
   a_call_two: assert property (idle && stk_cmd_in.call && !take && !io_req_in.wr
      |-> ##3 sp_ff == $past(sp_ff, 3) - 2'd2) else $error("call step");
   a_sp_upper: assert property (stack_ptr_out[15:12] == 4'h0)
      else $error("pointer upper bits");
   a_low_write: assert property (io_req_in.wr && hit_spl
      |=> $stable(sp_ff) && temp_ff == $past(io_req_in.wdata)) else $error("low write");
   a_pair_read: assert property (io_req_in.rd && hit_spl && !io_req_in.wr ##1
      io_req_in.rd && hit_sph && !io_req_in.wr
      |=> rdata_ff == 8'($past(sp_ff, 2) >> 8)) else $error("pair read");
   a_entry_len: assert property (take && !sleeping_in |=> s_entry)
      else $error("entry length");
   a_wake_len: assert property (take && sleeping_in
      |=> (state_ff == csi_pkg::ST_WAKE)[*4] ##1 s_entry) else $error("wake length");
   a_return_from_irq_instr_len: assert property (idle && stk_cmd_in.return_from_irq_instr && !take |=> s_return_from_irq_instr)
      else $error("return length");
   a_take_gate: assert property (take |-> gie_ff && irq_req[win_idx] && !cli_in
      ##1 !gie_ff) else $error("take gating");
   a_cli_block: assert property (cli_in && idle |=> idle && !gie_ff)
      else $error("disable not immediate");

endmodule : csi_stack_irq_ctrl

// >>> csi_stack_mem_model.sv
`timescale 1ns/10ps
// behavioural data memory that holds the stack
module csi_stack_mem_model (
   // clock
   input  wire logic                  ref_clk_in,
   // request from the stack logic
   input  wire csi_pkg::csi_mem_req_s mem_req_in,
   // read answer
   output logic [7:0]                 rdata_out
);
   logic [7:0] mem [0:4095];

   initial rdata_out = 8'h00;

   // answer one cycle after the read; otherwise scramble so stale bytes never pass
   always @(posedge ref_clk_in)
   begin
      if (mem_req_in.we)
         mem[mem_req_in.addr[11:0]] <= mem_req_in.wdata;
      rdata_out <= mem_req_in.re ? mem[mem_req_in.addr[11:0]] : ~rdata_out;
   end
endmodule : csi_stack_mem_model

// >>> csi_stack_irq_ctrl_test.sv
`timescale 1ns/10ps
`include "csi_defs.svh"
module csi_stack_irq_ctrl_test;
   localparam int NV = 8;
   logic                  clk, rst, hit, hit_s, busy, rv, vv, gie, done, sei, cli, vts;
   csi_pkg::csi_bus_req_s req;
   csi_pkg::csi_stk_cmd_s cmd;
   csi_pkg::csi_mem_req_s mreq;
   logic [7:0]            rdata, mrdata, pdata;
   logic [15:0]           rpc, vpc, sp, caddr, pc, v;
   logic [NV-2:0]         cond, en, clr, flag;
   logic                  fuse, lk_a, slp, swr, sw_s;
   logic [15:0]           rst_pc;
   int                    err_count, cmp_count, n, k;

   // source 6 is a level type so both source kinds are exercised
   csi_stack_irq_ctrl #(.FLAG_TYPE_MASK(7'h3f)) u_csi_stack_irq_ctrl (.ref_clk_in(clk),
      .reset_in(rst), .io_req_in(req),
      .io_rdata_out(rdata), .io_hit_out(hit), .status_flags_reg_wr_out(swr), .alu_flags_in(7'h00),
      .stk_cmd_in(cmd), .push_data_in(pdata), .call_addr_in(caddr), .pc_in(pc),
      .instr_done_in(done), .sleeping_in(slp), .sei_in(sei), .cli_in(cli), .busy_out(busy),
      .ret_pc_out(rpc), .ret_valid_out(rv), .vec_pc_out(vpc), .vec_valid_out(vv),
      .reset_pc_out(rst_pc), .stack_ptr_out(sp), .global_irq_en_out(gie), .mem_req_out(mreq),
      .mem_rdata_in(mrdata), .vector_table_select_in(vts),
      .reset_vector_relocate_fuse_in(fuse), .boot_lock_bit_a_in(lk_a),
      .boot_lock_bit_b_in(1'b0), .irq_cond_in(cond), .irq_en_in(en),
      .irq_flag_clr_in(clr), .irq_flag_out(flag));
   csi_stack_mem_model u_csi_stack_mem_model (.ref_clk_in(clk), .mem_req_in(mreq),
      .rdata_out(mrdata));

   // expected vector address: relocation base plus slot stride
   function automatic logic [15:0] exp_vec(input logic sel, input int src);
      return (sel ? `CSI_BOOT_START : 16'h0000) + 16'((src + 1) * 2);
   endfunction : exp_vec

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // one register access; hit sampled inside the request cycle
   task automatic bus(input logic r, input logic w, input logic io, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      req <= '{r, w, io, a, d};
      @(posedge clk);
      hit_s = hit;
      sw_s = swr;
      req <= '0;
      @(posedge clk);
      #1;
   endtask : bus

   task automatic stk(input logic [4:0] c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= '0;
      #1;
   endtask : stk

   // instruction boundary, optionally carrying the enable or disable instruction
   task automatic bnd(input logic s, input logic c);
      @(posedge clk);
      done <= 1'b1;
      sei <= s;
      cli <= c;
      @(posedge clk);
      {done, sei, cli} <= '0;
      #1;
   endtask : bnd

   // bounded wait: 0 busy clear, 1 return valid, 2 vector valid
   task automatic wt(input int s);
      n = 0;
      while (n < 16 && !((s == 0 && busy === 1'b0) || (s == 1 && rv === 1'b1) ||
                         (s == 2 && vv === 1'b1)))
      begin
         @(posedge clk);
         #1 n++;
      end
   endtask : wt

   task automatic close_out;
      $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (5000) @(posedge clk);
      err_count++;
      close_out();
   end

   initial
   begin
      {rst, req, cmd, pdata, caddr, pc, done, sei, cli, vts, cond, en, clr, fuse, lk_a, slp} = '0;
      rst = 1'b1;
      err_count = 0;
      cmp_count = 0;
      void'($urandom(32'h675dc03d));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus(1, 0, 0, 8'h5d, 8'h00); chk(rdata, 8'hff, "sp low rst");
      bus(1, 0, 0, 8'h5e, 8'h00); chk(rdata, 8'h08, "sp high rst");
      repeat (4)
      begin
         v = 16'h0100 + 16'($urandom % 16'h0700);
         k = int'(sp);
         // low byte first, high nibble junk must drop
         bus(0, 1, 1, 8'h3d, v[7:0]); chk(sp, 16'(k), "low only");
         bus(0, 1, 1, 8'h3e, {4'($urandom), v[11:8]}); chk(sp, v, "sp pair");
         bus(1, 0, 0, `CSI_TEMP_DADDR, 8'h00); chk(rdata, v[7:0], "temp");
      end
      bus(1, 0, 1, 8'h3d, 8'h00); chk(rdata, v[7:0], "rd low");
      bus(1, 0, 1, 8'h3e, 8'h00); chk(rdata, {4'h0, v[11:8]}, "rd high");
      bus(1, 0, 0, 8'h60, 8'h00); chk({hit_s, rdata}, 9'h000, "unmapped");
      // back-to-back pair read, high byte must come from the latched copy
      @(posedge clk);
      req <= '{1'b1, 1'b0, 1'b0, 8'h5d, 8'h00};
      @(posedge clk);
      req <= '{1'b1, 1'b0, 1'b0, 8'h5e, 8'h00};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      #1 chk(rdata, {4'h0, v[11:8]}, "pair read");
      bus(0, 1, 1, 8'h3f, 8'h80); chk({sw_s, gie}, 2'b11, "status write");
      bus(1, 0, 0, 8'h5f, 8'h00); chk(rdata, 8'h80, "status read");
      bus(0, 1, 0, 8'h5f, 8'h00); chk(gie, 1'b0, "status clear");
      $display("test registers done");
      pdata <= 8'($urandom);
      stk(5'h10); wt(0); chk(sp, v - 1, "push");
      // the registered write lands in memory one edge later
      @(posedge clk);
      #1;
      chk(u_csi_stack_mem_model.mem[v[11:0]], pdata, "push byte");
      stk(5'h08); wt(0); chk(sp, v, "pop");
      caddr <= 16'($urandom);
      stk(5'h04); wt(0); chk(sp, v - 2, "call");
      stk(5'h01); wt(1); chk(16'(n), 16'h0004, "return_from_irq_instr cycles");
      chk(rpc, caddr, "ret pc"); chk(sp, v, "return_from_irq_instr sp"); chk(gie, 1'b1, "return_from_irq_instr gie");
      $display("test stack done");
      en <= '1;
      for (int s = 0; s < 2; s++)
      begin
         k = $urandom_range(NV - 3, 1);
         vts <= s[0];
         pc <= 16'($urandom);
         @(posedge clk);
         cond <= (7'h01 << k) | (7'h01 << (k - 1));
         @(posedge clk);
         cond <= '0;
         bnd(1, 0); chk(busy, 1'b0, "sei defers"); chk(gie, 1'b1, "sei");
         bnd(0, 0); chk(gie, 1'b0, "entry gie");
         wt(2); chk(16'(n), 16'h0004, "entry cycles");
         chk(vpc, exp_vec(s[0], k - 1), "vector");
         chk(flag[k - 1], 1'b0, "ack"); chk(flag[k], 1'b1, "pending");
         chk(sp, v - 2, "entry sp");
         stk(5'h01); wt(1); chk(rpc, pc, "irq ret"); chk(gie, 1'b1, "gie");
         bnd(0, 0); wt(2); chk(vpc, exp_vec(s[0], k), "second");
         stk(5'h01); wt(1);
         @(posedge clk);
         cond <= 7'h01 << k;
         @(posedge clk);
         cond <= '0;
         bnd(0, 1); wt(2); chk(16'(n), 16'h0010, "cli blocks");
         clr <= 7'h01 << k;
         @(posedge clk);
         clr <= '0;
         @(posedge clk);
         #1 chk(flag[k], 1'b0, "sw clear");
         $display("test interrupt pass %0d done", s);
      end
      // lock bit a guards the application section only
      cond <= 7'h01;
      @(posedge clk);
      cond <= '0;
      pc <= 16'h0100;
      lk_a <= 1'b1;
      bnd(1, 0); bnd(0, 0); wt(2); chk(16'(n), 16'h0010, "lock blocks");
      pc <= 16'h7100;
      slp <= 1'b1;
      wt(2); chk(16'(n), 16'h0009, "wake cycles");
      slp <= 1'b0;
      chk(vpc, exp_vec(1'b1, 0), "boot vector");
      stk(5'h01); wt(1); chk(sp, v, "lock sp");
      // level source: no latch, asks only while present
      cond <= 7'h40;
      @(posedge clk);
      #1 chk(flag[6], 1'b0, "level no flag");
      cond <= '0;
      bnd(0, 0); wt(2); chk(16'(n), 16'h0010, "level gone");
      cond <= 7'h40;
      bnd(0, 0); wt(2); chk(vpc, exp_vec(1'b1, 6), "level vector");
      cond <= '0;
      stk(5'h01); wt(1);
      $display("test lock and level done");
      chk(rst_pc, 16'h0000, "reset vector low");
      fuse <= 1'b1;
      @(posedge clk);
      #1 chk(rst_pc, `CSI_BOOT_START, "reset vector boot");
      close_out();
   end
endmodule : csi_stack_irq_ctrl_test
